// file: tb/fsl_jtag_host.sv
// JTAG host model that walks the TAP state machine.
// Assumes a 100 MHz bench clock; TCK is high 8 clocks and low 9, still between scans.
`default_nettype none
module fsl_jtag_host (
    // Clock
    input wire logic clock,
    // JTAG pins
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One TCK cycle; TDO taken late in the low phase, once it has settled
    task automatic step(input logic m, input logic d, output logic o);
        @(negedge clock);
        tms = m;
        tdi = d;
        repeat (8) @(negedge clock);
        o = tdo;
        tck = 1'b1;
        repeat (8) @(negedge clock);
        tck = 1'b0;
        tdi = ~d; // Stale data must not look valid
    endtask : step
    // Five ones reach Test-Logic-Reset, then park in Run-Test/Idle
    task automatic tap_reset();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : tap_reset
    // Scan IR or DR from Run-Test/Idle, LSB first, back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b0, o);
        if (ir)
            step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        // TCK then stands still, holding Run-Test/Idle
        step(1'b0, 1'b0, o);
    endtask : scan
endmodule : fsl_jtag_host
`default_nettype wire

// file: tb/tb_flash_security_lockout.sv
// Bench for the flash security interlock: program, secure, scan, recover.
// Assumes the JTAG host model drives the TAP pins.
`default_nettype none
module tb_flash_security_lockout;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ID = 32'h0a5c_3e61; // Arbitrary identity value
    logic clock, resetn, dev_resetn, prog_req, dbg_req, tck, tms, tdi, tdo, oen;
    logic prog_ack, dbg_ack, dbg_err, secured, dbg_enable, erase_busy, erase_done;
    logic [3:0] prog_addr, dbg_addr, a;
    logic [15:0] prog_data, dbg_rdata, prot;
    logic [15:0] mem [16]; // Expected array contents
    logic [31:0] cap;
    logic [6:0] div;
    int miscompares, checks;
    fsl_jtag_host u_host (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    fsl_lockout #(.ID_VALUE(ID)) u_dut (.clock(clock), .resetn(resetn),
        .dev_resetn(dev_resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oen(oen), .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
        .prog_ack(prog_ack), .dbg_req(dbg_req), .dbg_addr(dbg_addr), .dbg_ack(dbg_ack),
        .dbg_err(dbg_err), .dbg_rdata(dbg_rdata), .secured(secured),
        .dbg_enable(dbg_enable), .prot(prot), .erase_busy(erase_busy),
        .erase_done(erase_done));
    // Free-running system clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : check
    // Bounded wait for the erase busy level
    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (erase_busy !== lvl)
        begin
            tick(1);
            n++;
            if (n > lim)
            begin
                check(1'b0, 1'b1, "erase wait timed out");
                finish_test();
            end
        end
    endtask : wait_busy
    task automatic por();
        resetn = 1'b0;
        tick(10);
        resetn = 1'b1;
        tick(8);
    endtask : por
    task automatic dev_rst();
        dev_resetn = 1'b0;
        tick(4);
        dev_resetn = 1'b1;
        tick(10);
    endtask : dev_rst
    // Ack is looked at in the one cycle it stands; bits can only fall
    task automatic prog(input logic [3:0] ad, input logic [15:0] d);
        tick(1);
        prog_req = 1'b1;
        prog_addr = ad;
        prog_data = d;
        tick(1);
        check(prog_ack, 1'b1, "program ack");
        prog_req = 1'b0;
        mem[ad] = mem[ad] & d;
    endtask : prog
    task automatic read(input logic [3:0] ad, input logic err);
        tick(1);
        dbg_req = 1'b1;
        dbg_addr = ad;
        tick(1);
        dbg_req = 1'b0;
        check(dbg_err, err, "read refusal");
        tick(1);
        check(dbg_ack, !err, "read ack");
        if (!err)
            check(dbg_rdata, mem[ad], "read data");
    endtask : read
    initial
    begin
        resetn = 1'b0;
        dev_resetn = 1'b1;
        prog_req = 1'b0;
        dbg_req = 1'b0;
        prog_addr = '0;
        dbg_addr = '0;
        prog_data = '0;
        miscompares = 0;
        checks = 0;
        foreach (mem[i]) mem[i] = 16'hffff;
        void'($urandom(32'h5fac));
        tick(10);
        resetn = 1'b1;
        tick(8);
        check(secured, 1'b0, "erased word must not secure");
        check(dbg_enable, 1'b1, "debug enabled");
        repeat (8)
        begin
            a = 4'($urandom_range(15, 8));
            prog(a, 16'($urandom));
            read(a, 1'b0);
        end
        $display("test program done");
        prog(4'h7, fsl_pkg::SEC_WORD);
        por();
        check(secured, 1'b1, "secured after power-on");
        check(dbg_enable, 1'b0, "debug disabled");
        check(prot, mem[8], "protection loaded");
        read(4'h8, 1'b1);
        u_host.tap_reset();
        u_host.scan(1'b1, 4, 32'(fsl_pkg::IR_IDCODE), cap);
        check(cap[3:0], 4'h1, "IR capture");
        u_host.scan(1'b0, 32, 32'h0, cap);
        check(cap, ID, "ID register while secured");
        check(oen, 1'b1, "TDO released outside shifts");
        $display("test secure done");
        div = 7'($urandom_range(6, 1));
        u_host.scan(1'b1, 4, 32'(fsl_pkg::IR_LOCKOUT), cap);
        u_host.scan(1'b0, 7, 32'(div), cap);
        wait_busy(1'b1, 20);
        check(secured, 1'b1, "secured during erase");
        wait_busy(1'b0, 16 * (div + 1) + 20);
        check(erase_done, 1'b1, "erase done");
        check(prot, 16'h0000, "protection cleared");
        check(secured, 1'b1, "secured until reset");
        foreach (mem[i]) mem[i] = 16'hffff;
        u_host.tap_reset();
        dev_rst();
        check(secured, 1'b0, "unsecured after both resets");
        for (int i = 0; i < 16; i++)
            read(4'(i), 1'b0);
        $display("test recovery done");
        prog(4'h7, fsl_pkg::SEC_WORD);
        por();
        // Leave Test-Logic-Reset so that only a later TAP reset counts
        u_host.tap_reset();
        prog(4'h7, fsl_pkg::UNSEC_WORD);
        dev_rst();
        check(secured, 1'b1, "TAP not yet reset");
        u_host.tap_reset();
        dev_rst();
        check(secured, 1'b0, "zero word unsecures");
        read(4'h7, 1'b0);
        $display("test zero word done");
        finish_test();
    end
endmodule : tb_flash_security_lockout
`default_nettype wire

// file: verilog/fsl_flash.sv
// Array window of program flash holding the configuration field.
// Assumes one request a cycle; read data come from a register.
`default_nettype none
module fsl_flash (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Access
    input wire fsl_pkg::fsl_mem_req_type req,
    output logic [15:0] rdata
);
    // Cells are nonvolatile: no reset, power up erased
    logic [15:0] cell_ff [fsl_pkg::DEPTH] = '{default: fsl_pkg::ERASED_WORD};
    fsl_pkg::fsl_mem_reg_type r_ff; // Read register and check helper
    fsl_pkg::fsl_mem_reg_type nxt_r; // Its next value

    // Cell update: program ANDs, erase sets all ones
    always_ff @(posedge clock)
    begin
        if (req.en && req.erase)
            cell_ff[req.addr] <= fsl_pkg::ERASED_WORD;
        else if (req.en && req.we)
            cell_ff[req.addr] <= cell_ff[req.addr] & req.wdata;
    end

    // Read register and snapshot for the check
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.chk_we = req.en && req.we && !req.erase;
        nxt_r.chk_addr = req.addr;
        nxt_r.chk_old = cell_ff[req.addr];
        if (req.en && !req.we && !req.erase)
            nxt_r.rdata = cell_ff[req.addr];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign rdata = r_ff.rdata;

    a_prog_no_set: assert property (@(posedge clock) disable iff (!resetn)
        r_ff.chk_we |-> (cell_ff[r_ff.chk_addr] & ~r_ff.chk_old) == 16'h0000)
        else $error("Programming raised a flash bit");
endmodule : fsl_flash
`default_nettype wire

// file: verilog/fsl_lockout.sv
// Flash security interlock: sampling, debug gate, lockout recovery.
// Assumes JTAG and device reset pins are asynchronous to clock.
`default_nettype none
module fsl_lockout #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identity value
) (
    // Clock and power-on reset
    input wire logic clock,
    input wire logic resetn,
    // Device reset pin
    input wire logic dev_resetn,
    // JTAG pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oen,
    // Core flash programming
    input wire logic prog_req,
    input wire logic [3:0] prog_addr,
    input wire logic [15:0] prog_data,
    output logic prog_ack,
    // Debug-port flash reads
    input wire logic dbg_req,
    input wire logic [3:0] dbg_addr,
    output logic dbg_ack,
    output logic dbg_err,
    output logic [15:0] dbg_rdata,
    // Status
    output logic secured,
    output logic dbg_enable,
    output logic [15:0] prot,
    output logic erase_busy,
    output logic erase_done
);
    fsl_pkg::fsl_top_reg_type r_ff; // All interlock state
    fsl_pkg::fsl_top_reg_type nxt_r; // Its next value
    fsl_pkg::fsl_pins_type pins_in; // Raw pin levels
    fsl_pkg::fsl_tap_out_type tap; // TAP view
    fsl_pkg::fsl_mem_req_type mreq; // Array request this cycle
    logic [15:0] mem_rdata; // Registered array data
    logic tap_tdo; // TAP serial out
    logic tap_tdo_oen; // TAP drive enable, low drives
    logic rd_ok; // Debug read accepted
    logic start; // Recovery erase starts

    assign pins_in = '{tck: tck, tms: tms, tdi: tdi, dev_rstn: dev_resetn};

    // TAP works on the second synchroniser stage only
    fsl_tap #(
        .ID_VALUE(ID_VALUE)
    ) u_tap (
        .clock(clock),
        .resetn(resetn),
        .pins(r_ff.s2),
        .tap(tap),
        .tdo(tap_tdo),
        .tdo_oen(tap_tdo_oen)
    );

    // Configuration window of the array
    fsl_flash u_flash (
        .clock(clock),
        .resetn(resetn),
        .req(mreq),
        .rdata(mem_rdata)
    );

    // Recovery may begin once armed and the TAP sits in Run-Test/Idle
    assign start = r_ff.mode == fsl_pkg::ST_RUN && r_ff.armed &&
        tap.state == fsl_pkg::TAP_RTI && tap.ir == fsl_pkg::IR_LOCKOUT;

    // Interlock sequencing
    always_comb
    begin
        nxt_r = r_ff;
        mreq = '0;
        rd_ok = 1'b0;
        nxt_r.s1 = pins_in;
        nxt_r.s2 = r_ff.s1;
        nxt_r.dbg_ack = 1'b0;
        nxt_r.dbg_err = 1'b0;
        nxt_r.prog_ack = 1'b0;
        // TAP reset counts towards the pair of resets
        if (tap.state == fsl_pkg::TAP_TLR)
            nxt_r.tap_seen = 1'b1;
        // New divider arms the recovery
        if (tap.div_upd)
        begin
            nxt_r.div = tap.div;
            nxt_r.armed = 1'b1;
        end
        case (r_ff.mode)
            // Read the security word
            fsl_pkg::ST_SAMP:
            begin
                mreq.en = 1'b1;
                mreq.addr = fsl_pkg::SEC_IDX;
                nxt_r.mode = fsl_pkg::ST_LATCH_SEC;
            end
            // Latch the flag; a pending change needs the TAP reset too
            fsl_pkg::ST_LATCH_SEC:
            begin
                mreq.en = 1'b1;
                mreq.addr = fsl_pkg::PROT_IDX;
                if (!r_ff.pend || r_ff.tap_seen)
                begin
                    nxt_r.secured = mem_rdata == fsl_pkg::SEC_WORD;
                    nxt_r.pend = 1'b0;
                end
                nxt_r.mode = fsl_pkg::ST_LATCH_PROT;
            end
            // Load the protection register
            fsl_pkg::ST_LATCH_PROT:
            begin
                nxt_r.prot = mem_rdata;
                nxt_r.mode = fsl_pkg::ST_RUN;
            end
            // Normal operation: recovery, then program, then debug read
            fsl_pkg::ST_RUN:
            begin
                if (start)
                begin
                    nxt_r.mode = fsl_pkg::ST_ERASE;
                    nxt_r.armed = 1'b0;
                    nxt_r.busy = 1'b1;
                    nxt_r.done = 1'b0;
                    nxt_r.cnt = '0;
                    nxt_r.idx = fsl_pkg::FIRST_IDX;
                end
                else if (prog_req)
                begin
                    mreq = '{en: 1'b1, we: 1'b1, erase: 1'b0, addr: prog_addr,
                        wdata: prog_data};
                    nxt_r.prog_ack = 1'b1;
                    // Zero word takes effect only after both resets
                    if (prog_addr == fsl_pkg::SEC_IDX)
                    begin
                        nxt_r.pend = 1'b1;
                        nxt_r.tap_seen = 1'b0;
                    end
                end
                else if (dbg_req && !r_ff.secured)
                begin
                    mreq.en = 1'b1;
                    mreq.addr = dbg_addr;
                    rd_ok = 1'b1;
                end
            end
            // Erase one word per divided tick; security word goes last
            fsl_pkg::ST_ERASE:
            begin
                if (r_ff.cnt == r_ff.div)
                begin
                    nxt_r.cnt = '0;
                    mreq.en = 1'b1;
                    mreq.erase = 1'b1;
                    mreq.addr = r_ff.idx;
                    nxt_r.idx = r_ff.idx + 4'h1;
                    if (r_ff.idx == fsl_pkg::SEC_IDX)
                    begin
                        nxt_r.mode = fsl_pkg::ST_DONE;
                        nxt_r.busy = 1'b0;
                        nxt_r.done = 1'b1;
                        nxt_r.prot = '0;
                        nxt_r.pend = 1'b1;
                        nxt_r.tap_seen = 1'b0;
                    end
                end
                else
                    nxt_r.cnt = r_ff.cnt + 7'h01;
            end
            // Recovered; wait for resets, flag stays as latched
            fsl_pkg::ST_DONE: ;
            default: nxt_r.mode = fsl_pkg::ST_SAMP;
        endcase
        // Secured or busy: debug reads refused
        nxt_r.dbg_err = dbg_req && !rd_ok;
        nxt_r.rd_pend = rd_ok;
        if (r_ff.rd_pend)
        begin
            nxt_r.dbg_ack = 1'b1;
            nxt_r.dbg_rdata = mem_rdata;
        end
        // Device reset resamples, but never cuts an erase short
        if (!r_ff.s2.dev_rstn && r_ff.mode != fsl_pkg::ST_ERASE && !start)
        begin
            mreq = '0; // No write lands without its ack
            nxt_r.dbg_err = dbg_req; // Reads refused while held
            nxt_r.mode = fsl_pkg::ST_SAMP;
            nxt_r.armed = 1'b0;
            nxt_r.rd_pend = 1'b0;
            nxt_r.dbg_ack = 1'b0;
            nxt_r.prog_ack = 1'b0;
            nxt_r.done = 1'b0;
        end
        // Debug only when unsecured and running
        nxt_r.dbg_en = !nxt_r.secured && nxt_r.mode == fsl_pkg::ST_RUN;
    end

    // Secured until the first sample proves otherwise
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            r_ff <= '0;
            r_ff.s1 <= '1;
            r_ff.s2 <= '1;
            r_ff.secured <= 1'b1;
            r_ff.div <= fsl_pkg::DIV_RESET;
            r_ff.mode <= fsl_pkg::ST_SAMP;
        end
        else
            r_ff <= nxt_r;
    end

    // TDO is driven as a pin pair straight from the TAP flops
    assign tdo = tap_tdo;
    assign tdo_oen = tap_tdo_oen;
    assign prog_ack = r_ff.prog_ack;
    assign dbg_ack = r_ff.dbg_ack;
    assign dbg_err = r_ff.dbg_err;
    assign dbg_rdata = r_ff.dbg_rdata;
    assign secured = r_ff.secured;
    assign dbg_enable = r_ff.dbg_en;
    assign prot = r_ff.prot;
    assign erase_busy = r_ff.busy;
    assign erase_done = r_ff.done;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_dbg_blocked: assert property (
        r_ff.secured && dbg_req |=> dbg_err && !dbg_ack ##1 !dbg_ack)
        else $error("Secured device answered a debug read");
    a_dbg_off: assert property (secured |-> !dbg_enable)
        else $error("Debug enabled while secured");
    a_sec_hold: assert property (
        secured && r_ff.mode != fsl_pkg::ST_LATCH_SEC |=> secured)
        else $error("Secured flag dropped outside sampling");
    a_erase_keep: assert property (
        r_ff.mode == fsl_pkg::ST_ERASE |=> $stable(secured))
        else $error("Security changed during erase");
    a_erase_start: assert property (start |=> erase_busy [*2])
        else $error("Erase did not start in Run-Test/Idle");
    a_done_clear: assert property (
        $rose(erase_done) |-> prot == 16'h0000 && r_ff.pend && !erase_busy)
        else $error("Recovery left protection or state set");
    a_sec_last: assert property (
        r_ff.mode == fsl_pkg::ST_ERASE && mreq.erase && mreq.addr == fsl_pkg::SEC_IDX
        |=> r_ff.mode == fsl_pkg::ST_DONE)
        else $error("Security word not erased last");
    a_sample_only: assert property (
        $changed(secured) |-> $past(r_ff.mode) == fsl_pkg::ST_LATCH_SEC)
        else $error("Secured flag changed outside sampling");
    a_both_resets: assert property (
        $fell(secured) && $past(r_ff.pend) |-> $past(r_ff.tap_seen))
        else $error("Unsecured without TAP reset");
    a_zero_pend: assert property (
        r_ff.mode == fsl_pkg::ST_RUN && !start && prog_req && r_ff.s2.dev_rstn &&
        prog_addr == fsl_pkg::SEC_IDX |=> r_ff.pend && prog_ack)
        else $error("Security word program not held pending");
endmodule : fsl_lockout
`default_nettype wire

// file: verilog/fsl_pkg.sv
// Constants and types of the flash security interlock.
// Assumes one 100 MHz clock; JTAG pins arrive unsynchronised.
// Behaviour
// - Security word value keeps device secured persistently
// - Secured device disables core debug only
// - TAP always gives boundary scan and ID; this TAP has ID and bypass, no boundary scan register
// - Secured device refuses debug flash access
// - Recovery erases whole array, clears protection
// - Unsecure only at reset after erase completes
// - Host shifts divider into 7-bit register
// - Erase starts when TAP enters Run-Test/Idle
// - TAP and device reset after recovery
// - Zero security word unsecures without erase
// - Zero word takes effect after both resets
// - Programming only clears bits; erase sets
// - Power-on reset resets the TAP
`default_nettype none
package fsl_pkg;
    // Security word values
    localparam logic [15:0] SEC_WORD = 16'he70a; // Secures the device
    localparam logic [15:0] UNSEC_WORD = 16'h0000; // Unsecures without erase
    localparam logic [15:0] ERASED_WORD = 16'hffff; // Erased cell state
    // Configuration window, words 0x1ff0..0x1fff
    localparam logic [20:0] CFG_BASE = 21'h001ff0; // Base of the window
    localparam int unsigned DEPTH = 16; // Words held
    localparam logic [3:0] SEC_IDX = 4'h7; // Security word 0x1ff7
    localparam logic [3:0] PROT_IDX = 4'h8; // Protection word
    localparam logic [3:0] FIRST_IDX = 4'h8; // Erase starts after security word
    // TAP instructions and registers
    localparam logic [3:0] IR_CAPTURE = 4'h1; // Fixed IR capture pattern
    localparam logic [3:0] IR_IDCODE = 4'h2; // ID register
    localparam logic [3:0] IR_LOCKOUT = 4'h8; // Erase-unlock
    localparam logic [3:0] IR_BYPASS = 4'hf; // Bypass
    localparam logic [4:0] MSB_ID = 5'h1f; // ID register top bit
    localparam logic [4:0] MSB_DIV = 5'h06; // Divider register top bit
    localparam logic [6:0] DIV_RESET = 7'h00; // Divider after reset

    // Pin levels that need synchronising
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic dev_rstn;
    } fsl_pins_type;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
        TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UPD_IR = 4'hf
    } fsl_tap_state_type;

    typedef enum logic [2:0] {
        ST_SAMP = 3'h0, ST_LATCH_SEC = 3'h1, ST_LATCH_PROT = 3'h2,
        ST_RUN = 3'h3, ST_ERASE = 3'h4, ST_DONE = 3'h5
    } fsl_mode_type;

    // One access to the array
    typedef struct packed {
        logic en;
        logic we;
        logic erase;
        logic [3:0] addr;
        logic [15:0] wdata;
    } fsl_mem_req_type;

    // What the TAP tells the interlock
    typedef struct packed {
        fsl_tap_state_type state;
        logic [3:0] ir;
        logic div_upd;
        logic [6:0] div;
    } fsl_tap_out_type;

    typedef struct packed {
        logic tck_d;
        fsl_tap_state_type state;
        logic [3:0] ir;
        logic [3:0] ir_sr;
        logic [31:0] dr_sr;
        logic byp;
        logic div_upd;
        logic [6:0] div;
        logic tdo;
        logic tdo_oen;
    } fsl_tap_reg_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic chk_we;
        logic [3:0] chk_addr;
        logic [15:0] chk_old;
    } fsl_mem_reg_type;

    typedef struct packed {
        fsl_pins_type s1;
        fsl_pins_type s2;
        fsl_mode_type mode;
        logic secured;
        logic dbg_en;
        logic [15:0] prot;
        logic armed;
        logic [6:0] div;
        logic [6:0] cnt;
        logic [3:0] idx;
        logic pend;
        logic tap_seen;
        logic rd_pend;
        logic dbg_ack;
        logic dbg_err;
        logic [15:0] dbg_rdata;
        logic prog_ack;
        logic busy;
        logic done;
    } fsl_top_reg_type;
endpackage : fsl_pkg
`default_nettype wire

// file: verilog/fsl_tap.sv
// Chip-level JTAG TAP: IR, ID, bypass and the divider register.
// Assumes pin levels already synchronised to clock; TCK well below it.
`default_nettype none
module fsl_tap #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identity value
) (
    // Clock and power-on reset
    input wire logic clock,
    input wire logic resetn,
    // Synchronised pin levels
    input wire fsl_pkg::fsl_pins_type pins,
    // Decoded view and serial output
    output fsl_pkg::fsl_tap_out_type tap,
    output logic tdo,
    output logic tdo_oen
);
    fsl_pkg::fsl_tap_reg_type r_ff; // All TAP state
    fsl_pkg::fsl_tap_reg_type nxt_r; // Its next value
    logic [4:0] msb; // Top of the selected data register

    // Standard TAP transition on TMS
    function automatic fsl_pkg::fsl_tap_state_type step(
        input fsl_pkg::fsl_tap_state_type s, input logic m);
        case (s)
            fsl_pkg::TAP_TLR: step = m ? fsl_pkg::TAP_TLR : fsl_pkg::TAP_RTI;
            fsl_pkg::TAP_RTI: step = m ? fsl_pkg::TAP_SEL_DR : fsl_pkg::TAP_RTI;
            fsl_pkg::TAP_SEL_DR: step = m ? fsl_pkg::TAP_SEL_IR : fsl_pkg::TAP_CAP_DR;
            fsl_pkg::TAP_CAP_DR: step = m ? fsl_pkg::TAP_EX1_DR : fsl_pkg::TAP_SH_DR;
            fsl_pkg::TAP_SH_DR: step = m ? fsl_pkg::TAP_EX1_DR : fsl_pkg::TAP_SH_DR;
            fsl_pkg::TAP_EX1_DR: step = m ? fsl_pkg::TAP_UPD_DR : fsl_pkg::TAP_PA_DR;
            fsl_pkg::TAP_PA_DR: step = m ? fsl_pkg::TAP_EX2_DR : fsl_pkg::TAP_PA_DR;
            fsl_pkg::TAP_EX2_DR: step = m ? fsl_pkg::TAP_UPD_DR : fsl_pkg::TAP_SH_DR;
            fsl_pkg::TAP_UPD_DR: step = m ? fsl_pkg::TAP_SEL_DR : fsl_pkg::TAP_RTI;
            fsl_pkg::TAP_SEL_IR: step = m ? fsl_pkg::TAP_TLR : fsl_pkg::TAP_CAP_IR;
            fsl_pkg::TAP_CAP_IR: step = m ? fsl_pkg::TAP_EX1_IR : fsl_pkg::TAP_SH_IR;
            fsl_pkg::TAP_SH_IR: step = m ? fsl_pkg::TAP_EX1_IR : fsl_pkg::TAP_SH_IR;
            fsl_pkg::TAP_EX1_IR: step = m ? fsl_pkg::TAP_UPD_IR : fsl_pkg::TAP_PA_IR;
            fsl_pkg::TAP_PA_IR: step = m ? fsl_pkg::TAP_EX2_IR : fsl_pkg::TAP_PA_IR;
            fsl_pkg::TAP_EX2_IR: step = m ? fsl_pkg::TAP_UPD_IR : fsl_pkg::TAP_SH_IR;
            fsl_pkg::TAP_UPD_IR: step = m ? fsl_pkg::TAP_SEL_DR : fsl_pkg::TAP_RTI;
            default: step = fsl_pkg::TAP_TLR;
        endcase
    endfunction : step

    // Act on TCK edges seen in the clock domain
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.tck_d = pins.tck;
        nxt_r.div_upd = 1'b0;
        msb = (r_ff.ir == fsl_pkg::IR_IDCODE) ? fsl_pkg::MSB_ID : fsl_pkg::MSB_DIV;
        // Rising TCK: move and capture or shift, always live
        if (pins.tck && !r_ff.tck_d)
        begin
            nxt_r.state = step(r_ff.state, pins.tms);
            case (r_ff.state)
                fsl_pkg::TAP_TLR: nxt_r.ir = fsl_pkg::IR_IDCODE;
                fsl_pkg::TAP_CAP_IR: nxt_r.ir_sr = fsl_pkg::IR_CAPTURE;
                fsl_pkg::TAP_SH_IR: nxt_r.ir_sr = {pins.tdi, r_ff.ir_sr[3:1]};
                fsl_pkg::TAP_UPD_IR: nxt_r.ir = r_ff.ir_sr;
                fsl_pkg::TAP_CAP_DR:
                begin
                    nxt_r.byp = 1'b0;
                    nxt_r.dr_sr = (r_ff.ir == fsl_pkg::IR_IDCODE) ? ID_VALUE : '0;
                end
                fsl_pkg::TAP_SH_DR:
                begin
                    nxt_r.byp = pins.tdi;
                    for (int i = 0; i < 32; i++)
                        nxt_r.dr_sr[i] = (5'(i) == msb) ? pins.tdi :
                            ((5'(i) < msb) ? r_ff.dr_sr[(i + 1) % 32] : 1'b0);
                end
                fsl_pkg::TAP_UPD_DR:
                    // Seven-bit divider register of the unlock
                    if (r_ff.ir == fsl_pkg::IR_LOCKOUT)
                    begin
                        nxt_r.div = r_ff.dr_sr[6:0];
                        nxt_r.div_upd = 1'b1;
                    end
                default: ;
            endcase
        end
        // Falling TCK: present TDO, drive only while shifting
        if (!pins.tck && r_ff.tck_d)
        begin
            nxt_r.tdo_oen = !(r_ff.state == fsl_pkg::TAP_SH_IR ||
                r_ff.state == fsl_pkg::TAP_SH_DR);
            if (r_ff.state == fsl_pkg::TAP_SH_IR)
                nxt_r.tdo = r_ff.ir_sr[0];
            else if (r_ff.ir == fsl_pkg::IR_IDCODE || r_ff.ir == fsl_pkg::IR_LOCKOUT)
                nxt_r.tdo = r_ff.dr_sr[0];
            else
                nxt_r.tdo = r_ff.byp;
        end
    end

    // Power-on reset puts the TAP in Test-Logic-Reset
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            r_ff <= '0;
            r_ff.state <= fsl_pkg::TAP_TLR;
            r_ff.ir <= fsl_pkg::IR_IDCODE;
            r_ff.tdo_oen <= 1'b1;
            r_ff.tck_d <= 1'b1; // Matches the synchroniser reset level, no false edge
        end
        else
            r_ff <= nxt_r;
    end

    assign tap = '{state: r_ff.state, ir: r_ff.ir, div_upd: r_ff.div_upd, div: r_ff.div};
    assign tdo = r_ff.tdo;
    assign tdo_oen = r_ff.tdo_oen;

    a_tlr_idcode: assert property (@(posedge clock) disable iff (!resetn)
        r_ff.state == fsl_pkg::TAP_TLR && pins.tck && !r_ff.tck_d
        |=> r_ff.ir == fsl_pkg::IR_IDCODE)
        else $error("IR not reset to ID in Test-Logic-Reset");
endmodule : fsl_tap
`default_nettype wire
